// File: pkg/dma_pkg.sv
// constants, field layout and state type for the two-channel transfer engine
package dma_pkg;
  localparam int ADDR_W = 26;
  localparam int CNT_W = 20;
  localparam int DATA_W = 16;
  localparam int CTL_W = 13;
  // register map, byte addresses
  localparam logic [6:0] OFF_CH1 = 7'h10;
  localparam logic [6:0] OFF_SWREQ = 7'h20;
  localparam logic [6:0] OFF_STATUS = 7'h24;
  localparam logic [3:0] REG_REQ_ADDR = 4'h0;
  localparam logic [3:0] REG_TGT_ADDR = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hc;
  // control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_FLY = 1;
  localparam int CTL_WORD = 2;
  localparam int CTL_DIR = 3;
  localparam int CTL_RMODE = 4;
  localparam int CTL_TMODE = 6;
  localparam int CTL_RIO = 8;
  localparam int CTL_TIO = 9;
  localparam int CTL_SRC = 10;
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic DIR_REQ_TO_TGT = 1'b0;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 2;
  localparam int ST_TERM = 4;
  localparam logic [CNT_W-1:0] CNT_DONE = 20'hfffff;
  localparam logic [2:0] BUF_BYTES = 3'h4;
  localparam logic [1:0] ACK_RST = 2'h3;
  localparam logic AV_WAIT_RST = 1'b1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FLY = 4'b0010,
    ST_RD = 4'b0100,
    ST_WR = 4'b1000
  } dma_state_t;
endpackage

// File: pkg/req_sel_if.sv
// request source selection between the engine and a channel selector
`timescale 1ns/1ns
interface req_sel_if;
  logic [7:0] sources;
  logic [2:0] sel;
  logic req;
  modport sel_side(input sources, input sel, output req);
  modport user(output sources, output sel, input req);
endinterface

// File: src/dma_req_select.sv
// one channel's hardware request multiplexer
`timescale 1ns/1ns
module dma_req_select (
  input wire logic mclk,
  input wire logic sys_rst,
  req_sel_if.sel_side rs
);
  typedef struct packed {
    logic req;
  } sel_state_t;
  sel_state_t r;
  sel_state_t n;

  always_comb begin
    n = r;
    n.req = rs.sources[rs.sel];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rs.req = r.req;

  chk_sel_follows_source: assert property (@(posedge mclk) disable iff (sys_rst)
    rs.sources[rs.sel] |=> rs.req) else $error("selected request not passed on");
endmodule

// File: src/dma_channel_transfer_control.sv
// two-channel transfer engine with avalon register slave and system bus master
`timescale 1ns/1ns
module dma_channel_transfer_control (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] channel_request_pin,
  input wire logic serial0_rx_full_request,
  input wire logic serial0_tx_empty_request,
  input wire logic serial1_rx_full_request,
  input wire logic serial1_tx_empty_request,
  input wire logic sync_tx_request,
  input wire logic sync_rx_request,
  input wire logic timer1_out,
  input wire logic timer2_out,
  output logic [1:0] channel_acknowledge_n,
  input wire logic end_of_process_n_in,
  output logic end_of_process_n_out,
  output logic end_of_process_n_oe,
  output logic [dma_pkg::ADDR_W-1:0] bus_addr,
  output logic [dma_pkg::DATA_W-1:0] bus_wdata,
  input wire logic [dma_pkg::DATA_W-1:0] bus_rdata,
  input wire logic bus_ready,
  output logic bus_mem_rd,
  output logic bus_mem_wr,
  output logic bus_io_rd,
  output logic bus_io_wr,
  output logic bus_word
);
  typedef struct packed {
    dma_pkg::dma_state_t st;
    logic ch;
    logic cyc;
    logic stop;
    logic [1:0][dma_pkg::ADDR_W-1:0] req_addr;
    logic [1:0][dma_pkg::ADDR_W-1:0] tgt_addr;
    logic [1:0][dma_pkg::CNT_W-1:0] count;
    logic [1:0][dma_pkg::CTL_W-1:0] ctrl;
    logic [1:0] swreq;
    logic [1:0] done;
    logic [1:0] term;
    logic [3:0][7:0] buffer;
    logic [2:0] fill;
    logic [2:0] wptr;
    logic [1:0] ack_n;
    logic eop_oe;
    logic eop_out;
    logic [dma_pkg::ADDR_W-1:0] bus_addr;
    logic [dma_pkg::DATA_W-1:0] wdata;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic word;
    logic av_wait;
    logic [31:0] av_rdata;
  } top_state_t;

  top_state_t r;
  top_state_t n;

  logic [1:0] hw_req;
  logic [1:0] pend;
  logic [1:0] fly_ok;
  logic [dma_pkg::CTL_W-1:0] cur_ctrl;
  logic cur_word;
  logic cur_dir;
  logic [dma_pkg::ADDR_W-1:0] cur_req;
  logic [dma_pkg::ADDR_W-1:0] cur_tgt;
  logic [dma_pkg::CNT_W-1:0] cur_count;
  logic [dma_pkg::CNT_W-1:0] cnt_dec;
  logic [dma_pkg::CNT_W:0] left;
  logic [2:0] fill_next;
  logic [2:0] wptr_next;
  logic src_is_req;
  logic src_io;
  logic dst_io;
  logic eop_in;
  logic acc;
  logic wr_now;
  logic xfer_any;
  logic last_xfer;
  logic [6:0] areg;
  logic [31:0] rdval;

  req_sel_if rs0 ();
  req_sel_if rs1 ();

  assign rs0.sources = {timer1_out, sync_rx_request, sync_tx_request,
    serial1_tx_empty_request, serial1_rx_full_request,
    serial0_tx_empty_request, serial0_rx_full_request, channel_request_pin[0]};
  assign rs1.sources = {timer2_out, sync_tx_request, sync_rx_request,
    serial0_rx_full_request, serial0_tx_empty_request,
    serial1_tx_empty_request, serial1_rx_full_request, channel_request_pin[1]};
  assign rs0.sel = r.ctrl[0][dma_pkg::CTL_SRC +: 3];
  assign rs1.sel = r.ctrl[1][dma_pkg::CTL_SRC +: 3];

  dma_req_select sel0 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rs(rs0.sel_side)
  );

  dma_req_select sel1 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rs(rs1.sel_side)
  );

  function automatic logic [dma_pkg::ADDR_W-1:0] adr_next(
    input logic [dma_pkg::ADDR_W-1:0] a,
    input logic [1:0] m,
    input logic w
  );
    logic [dma_pkg::ADDR_W-1:0] s;
    s = w ? 26'h2 : 26'h1;
    if (m == dma_pkg::AM_INC) begin
      return a + s;
    end else if (m == dma_pkg::AM_DEC) begin
      return a - s;
    end
    return a;
  endfunction

  // ends the buffer; completion also pulses the open-drain end line
  function automatic top_state_t finish_buf(input top_state_t s, input logic c, input logic ok);
    s.ctrl[c][dma_pkg::CTL_EN] = 1'b0;
    s.swreq[c] = 1'b0;
    s.st = dma_pkg::ST_IDLE;
    s.stop = 1'b0;
    if (ok) begin
      s.done[c] = 1'b1;
      s.eop_oe = 1'b1;
    end else begin
      s.term[c] = 1'b1;
    end
    return s;
  endfunction

  assign hw_req = {rs1.req, rs0.req};
  assign pend[0] = r.ctrl[0][dma_pkg::CTL_EN] & (hw_req[0] | r.swreq[0]);
  assign pend[1] = r.ctrl[1][dma_pkg::CTL_EN] & (hw_req[1] | r.swreq[1]);
  // fly-by falls back to two-cycle when the pairing does not allow it
  assign fly_ok[0] = r.ctrl[0][dma_pkg::CTL_FLY] & r.ctrl[0][dma_pkg::CTL_RIO]
    & ~r.ctrl[0][dma_pkg::CTL_TIO];
  assign fly_ok[1] = r.ctrl[1][dma_pkg::CTL_FLY] & r.ctrl[1][dma_pkg::CTL_RIO]
    & ~r.ctrl[1][dma_pkg::CTL_TIO];
  assign cur_ctrl = r.ctrl[r.ch];
  assign cur_word = cur_ctrl[dma_pkg::CTL_WORD];
  assign cur_dir = cur_ctrl[dma_pkg::CTL_DIR];
  assign cur_req = r.req_addr[r.ch];
  assign cur_tgt = r.tgt_addr[r.ch];
  assign cur_count = r.count[r.ch];
  assign cnt_dec = cur_count - (cur_word ? 20'h2 : 20'h1);
  assign left = {1'b0, cur_count} + 21'h1;
  assign fill_next = r.fill + (cur_word ? 3'h2 : 3'h1);
  assign wptr_next = r.wptr + (cur_word ? 3'h2 : 3'h1);
  assign src_is_req = (cur_dir == dma_pkg::DIR_REQ_TO_TGT);
  assign src_io = src_is_req ? cur_ctrl[dma_pkg::CTL_RIO] : cur_ctrl[dma_pkg::CTL_TIO];
  assign dst_io = src_is_req ? cur_ctrl[dma_pkg::CTL_TIO] : cur_ctrl[dma_pkg::CTL_RIO];
  // our own drive on the shared line must not read back as a stop
  assign eop_in = ~end_of_process_n_in & ~r.eop_oe;
  assign acc = (avs_read | avs_write) & r.av_wait;
  assign wr_now = avs_write & ~r.av_wait;
  assign xfer_any = r.cyc & bus_ready;
  assign last_xfer = xfer_any & (r.st != dma_pkg::ST_RD) & (cnt_dec == dma_pkg::CNT_DONE);
  assign areg = {avs_address[6:2], 2'h0};

  always_comb begin
    rdval = 32'h0;
    if (areg[6:5] == 2'h0) begin
      unique case (areg[3:0])
        dma_pkg::REG_REQ_ADDR: rdval = 32'(r.req_addr[areg[4]]);
        dma_pkg::REG_TGT_ADDR: rdval = 32'(r.tgt_addr[areg[4]]);
        dma_pkg::REG_COUNT: rdval = 32'(r.count[areg[4]]);
        dma_pkg::REG_CTRL: rdval = 32'(r.ctrl[areg[4]]);
        default: rdval = 32'h0;
      endcase
    end else if (areg == dma_pkg::OFF_SWREQ) begin
      rdval = 32'(r.swreq);
    end else if (areg == dma_pkg::OFF_STATUS) begin
      rdval[dma_pkg::ST_BUSY +: 2] = (r.st == dma_pkg::ST_IDLE) ? 2'h0 : (r.ch ? 2'h2 : 2'h1);
      rdval[dma_pkg::ST_DONE +: 2] = r.done;
      rdval[dma_pkg::ST_TERM +: 2] = r.term;
    end
  end

  always_comb begin
    n = r;
    n.eop_oe = 1'b0;
    n.eop_out = 1'b0;
    n.av_wait = ~acc;
    if (acc && avs_read) begin
      n.av_rdata = rdval;
    end
    // software clears go first so a hardware set in the same cycle wins
    if (wr_now) begin
      if (areg[6:5] == 2'h0) begin
        unique case (areg[3:0])
          dma_pkg::REG_REQ_ADDR: n.req_addr[areg[4]] = avs_writedata[dma_pkg::ADDR_W-1:0];
          dma_pkg::REG_TGT_ADDR: n.tgt_addr[areg[4]] = avs_writedata[dma_pkg::ADDR_W-1:0];
          dma_pkg::REG_COUNT: n.count[areg[4]] = avs_writedata[dma_pkg::CNT_W-1:0];
          dma_pkg::REG_CTRL: n.ctrl[areg[4]] = avs_writedata[dma_pkg::CTL_W-1:0];
          default: n.ctrl = r.ctrl;
        endcase
      end else if (areg == dma_pkg::OFF_SWREQ) begin
        n.swreq = r.swreq | avs_writedata[1:0];
      end else if (areg == dma_pkg::OFF_STATUS) begin
        n.done = r.done & ~avs_writedata[dma_pkg::ST_DONE +: 2];
        n.term = r.term & ~avs_writedata[dma_pkg::ST_TERM +: 2];
      end
    end
    if (r.st != dma_pkg::ST_IDLE && eop_in) begin
      n.stop = 1'b1;
    end
    if (xfer_any) begin
      n.cyc = 1'b0;
      n.mem_rd = 1'b0;
      n.mem_wr = 1'b0;
      n.io_rd = 1'b0;
      n.io_wr = 1'b0;
      n.ack_n = dma_pkg::ACK_RST;
    end
    unique case (r.st)
      dma_pkg::ST_IDLE: begin
        if (pend != 2'h0) begin
          n.ch = ~pend[0];
          n.stop = 1'b0;
          n.fill = 3'h0;
          n.wptr = 3'h0;
          n.st = fly_ok[~pend[0]] ? dma_pkg::ST_FLY : dma_pkg::ST_RD;
        end
      end
      dma_pkg::ST_FLY: begin
        if (!r.cyc) begin
          n.cyc = 1'b1;
          n.bus_addr = cur_tgt;
          n.mem_wr = ~cur_dir;
          n.mem_rd = cur_dir;
          n.word = cur_word;
          n.ack_n[r.ch] = 1'b0;
        end else if (bus_ready) begin
          n.count[r.ch] = cnt_dec;
          n.tgt_addr[r.ch] = adr_next(cur_tgt, cur_ctrl[dma_pkg::CTL_TMODE +: 2], cur_word);
          n.st = dma_pkg::ST_IDLE;
          if (cnt_dec == dma_pkg::CNT_DONE) begin
            n = finish_buf(n, r.ch, 1'b1);
          end else if (r.stop || eop_in) begin
            n = finish_buf(n, r.ch, 1'b0);
          end
        end
      end
      dma_pkg::ST_RD: begin
        // a suspended fill keeps the bus; the other channel waits meanwhile
        if (!r.cyc) begin
          if (r.stop || eop_in) begin
            if (r.fill == 3'h0) begin
              n = finish_buf(n, r.ch, 1'b0);
            end else begin
              n.st = dma_pkg::ST_WR;
            end
          end else if (pend[r.ch]) begin
            n.cyc = 1'b1;
            n.bus_addr = src_is_req ? cur_req : cur_tgt;
            n.io_rd = src_io;
            n.mem_rd = ~src_io;
            n.word = cur_word;
            n.ack_n[r.ch] = ~src_is_req;
          end
        end else if (bus_ready) begin
          n.buffer[r.fill[1:0]] = bus_rdata[7:0];
          if (cur_word) begin
            n.buffer[2'(r.fill[1:0] + 2'h1)] = bus_rdata[15:8];
          end
          n.fill = fill_next;
          if (src_is_req) begin
            n.req_addr[r.ch] = adr_next(cur_req, cur_ctrl[dma_pkg::CTL_RMODE +: 2], cur_word);
          end else begin
            n.tgt_addr[r.ch] = adr_next(cur_tgt, cur_ctrl[dma_pkg::CTL_TMODE +: 2], cur_word);
          end
          if (fill_next == dma_pkg::BUF_BYTES || 21'(fill_next) >= left || r.stop || eop_in) begin
            n.st = dma_pkg::ST_WR;
          end
        end
      end
      dma_pkg::ST_WR: begin
        if (!r.cyc) begin
          n.cyc = 1'b1;
          n.bus_addr = src_is_req ? cur_tgt : cur_req;
          n.io_wr = dst_io;
          n.mem_wr = ~dst_io;
          n.word = cur_word;
          n.wdata = {r.buffer[2'(r.wptr[1:0] + 2'h1)], r.buffer[r.wptr[1:0]]};
          n.ack_n[r.ch] = src_is_req;
        end else if (bus_ready) begin
          n.wptr = wptr_next;
          n.count[r.ch] = cnt_dec;
          if (src_is_req) begin
            n.tgt_addr[r.ch] = adr_next(cur_tgt, cur_ctrl[dma_pkg::CTL_TMODE +: 2], cur_word);
          end else begin
            n.req_addr[r.ch] = adr_next(cur_req, cur_ctrl[dma_pkg::CTL_RMODE +: 2], cur_word);
          end
          if (cnt_dec == dma_pkg::CNT_DONE) begin
            n = finish_buf(n, r.ch, 1'b1);
          end else if (wptr_next >= r.fill) begin
            if (r.stop || eop_in) begin
              n = finish_buf(n, r.ch, 1'b0);
            end else begin
              n.st = dma_pkg::ST_IDLE;
            end
          end
        end
      end
      default: n.st = dma_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= dma_pkg::ST_IDLE;
      r.ack_n <= dma_pkg::ACK_RST;
      r.av_wait <= dma_pkg::AV_WAIT_RST;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.av_rdata;
  assign avs_waitrequest = r.av_wait;
  assign channel_acknowledge_n = r.ack_n;
  assign end_of_process_n_out = r.eop_out;
  assign end_of_process_n_oe = r.eop_oe;
  assign bus_addr = r.bus_addr;
  assign bus_wdata = r.wdata;
  assign bus_mem_rd = r.mem_rd;
  assign bus_mem_wr = r.mem_wr;
  assign bus_io_rd = r.io_rd;
  assign bus_io_wr = r.io_wr;
  assign bus_word = r.word;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_fly_ack_whole: assert property ((r.st == dma_pkg::ST_FLY && r.cyc) |->
    channel_acknowledge_n[r.ch] == 1'b0) else $error("fly-by cycle without acknowledge");
  chk_fly_addr_target: assert property ((r.st == dma_pkg::ST_FLY && r.cyc) |->
    bus_addr == cur_tgt) else $error("fly-by address is not the target");
  chk_fly_mem_dir: assert property ((r.st == dma_pkg::ST_FLY && r.cyc) |->
    bus_mem_wr == ~cur_dir && bus_mem_rd == cur_dir && !bus_io_rd && !bus_io_wr)
    else $error("fly-by strobe does not match direction");
  chk_count_step: assert property ((xfer_any && r.st != dma_pkg::ST_RD) |=>
    cur_count == 20'($past(cur_count) - ($past(cur_word) ? 20'h2 : 20'h1)))
    else $error("count step wrong");
  chk_done_eop_pulse: assert property (last_xfer |=>
    end_of_process_n_oe && !end_of_process_n_out ##1 !end_of_process_n_oe)
    else $error("completion pulse missing");
  chk_done_flag_set: assert property (last_xfer |=> r.done[r.ch] &&
    !r.ctrl[r.ch][dma_pkg::CTL_EN] && r.st == dma_pkg::ST_IDLE)
    else $error("completion not recorded");
  chk_eop_term_fly: assert property ((r.st == dma_pkg::ST_FLY && xfer_any && eop_in &&
    !last_xfer) |=> r.term[r.ch] && !end_of_process_n_oe) else $error("stop not recorded");
  chk_tgt_step_inc: assert property ((r.st == dma_pkg::ST_FLY && xfer_any &&
    cur_ctrl[dma_pkg::CTL_TMODE +: 2] == dma_pkg::AM_INC) |=>
    cur_tgt == 26'($past(cur_tgt) + ($past(cur_word) ? 26'h2 : 26'h1)))
    else $error("target address not stepped");
  chk_two_ack_src: assert property ((r.st == dma_pkg::ST_RD && r.cyc && !src_is_req) |->
    channel_acknowledge_n == dma_pkg::ACK_RST) else $error("acknowledge during target access");
  chk_buf_bound: assert property ((r.st == dma_pkg::ST_WR) |->
    r.fill != 3'h0 && r.fill <= dma_pkg::BUF_BYTES) else $error("buffer fill out of range");

  cov_fly_done: cover property (r.st == dma_pkg::ST_FLY && last_xfer);
  cov_buf_full: cover property (r.st == dma_pkg::ST_RD ##1 r.st == dma_pkg::ST_WR && r.fill == 3'h4);
  cov_eop_stop: cover property (eop_in && r.st != dma_pkg::ST_IDLE ##[1:40] r.term != 2'h0);
  cov_sw_start: cover property (r.swreq != 2'h0 && hw_req == 2'h0 ##1 r.st != dma_pkg::ST_IDLE);
endmodule

// File: sim/dma_bus_partner.sv
// bus target model: memory that answers engine bus cycles after a chosen wait
`timescale 1ns/1ns
module dma_bus_partner (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cyc,
  input wire logic [25:0] addr,
  input wire logic [1:0] slow,
  output logic [15:0] bus_rdata,
  output logic bus_ready
);
  logic [1:0] wait_reg;
  logic gap_reg;
  logic [7:0] b;
  assign b = addr[7:0] ^ 8'ha5;
  // gap cycle: strobes may still stand right after our ready
  always @(posedge mclk) begin
    bus_ready <= 1'b0;
    gap_reg <= bus_ready;
    if (sys_rst) begin
      wait_reg <= 2'h0;
      bus_rdata <= 16'h0;
    end else if (bus_ready) begin
      bus_rdata <= ~bus_rdata; // released lines do not keep the old value
    end else if (cyc && !gap_reg) begin // target only answers, never starts
      wait_reg <= wait_reg + 2'h1;
      if (wait_reg >= slow) begin
        bus_ready <= 1'b1;
        bus_rdata <= {b, b};
        wait_reg <= 2'h0;
      end
    end
  end
endmodule

// File: sim/dma_channel_transfer_control_test.sv
// self-checking bench for the two-channel transfer engine
`timescale 1ns/1ns
module dma_channel_transfer_control_test;
  typedef struct packed {
    logic [4:0] k;
    logic [25:0] a;
    logic [15:0] d;
    logic [15:0] m;
    logic [1:0] ack;
  } note_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] avs_address = 7'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, eop_out, eop_oe, eop_n, bus_ready;
  logic mem_rd, mem_wr, io_rd, io_wr, bus_word;
  logic [9:0] hw = 10'h0;
  logic [1:0] ack_n;
  logic [1:0] slow = 2'h0;
  logic stop_n = 1'b1;
  logic loose = 1'b0;
  logic [dma_pkg::ADDR_W-1:0] bus_addr;
  logic [dma_pkg::DATA_W-1:0] bus_wdata, bus_rdata;
  logic [31:0] seed = 32'h201425a1;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_cyc = 0;
  int n_oe = 0;
  int n_side = 0;
  note_t exp_q[$];
  // hw bit per channel select: pin0 pin1 s0rx s0tx s1rx s1tx synctx syncrx t1 t2
  int map[2][8] = '{'{0, 2, 3, 4, 5, 6, 7, 8}, '{1, 4, 5, 3, 2, 7, 6, 9}};
  assign eop_n = (eop_oe && !eop_out) ? 1'b0 : stop_n; // open drain, pulled up
  logic side_io_rd, side_io_wr;
  // logic beside the io device: acknowledge with a memory strobe becomes the io strobe
  assign side_io_rd = !(&ack_n) && mem_wr;
  assign side_io_wr = !(&ack_n) && mem_rd;
  dma_channel_transfer_control u_dma_channel_transfer_control (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_request_pin(hw[1:0]),
    .serial0_rx_full_request(hw[2]), .serial0_tx_empty_request(hw[3]),
    .serial1_rx_full_request(hw[4]), .serial1_tx_empty_request(hw[5]),
    .sync_tx_request(hw[6]), .sync_rx_request(hw[7]), .timer1_out(hw[8]),
    .timer2_out(hw[9]), .channel_acknowledge_n(ack_n), .end_of_process_n_in(eop_n),
    .end_of_process_n_out(eop_out), .end_of_process_n_oe(eop_oe), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ready(bus_ready),
    .bus_mem_rd(mem_rd), .bus_mem_wr(mem_wr), .bus_io_rd(io_rd), .bus_io_wr(io_wr),
    .bus_word(bus_word)
  );
  dma_bus_partner u_dma_bus_partner (
    .mclk(mclk), .sys_rst(sys_rst), .cyc(mem_rd | mem_wr | io_rd | io_wr),
    .addr(bus_addr), .slow(slow), .bus_rdata(bus_rdata), .bus_ready(bus_ready)
  );
  initial begin
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic fail(input string s);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) fail("value differs");
  endtask
  task automatic cmp_bus(input note_t e, input note_t g);
    samples_checked++;
    if ({g.k, g.a, g.d & e.m, g.ack} !== {e.k, e.a, e.d & e.m, e.ack}) fail("bus cycle");
  endtask
  task automatic ex(input logic [4:0] k, input logic [25:0] a, input logic [15:0] d,
      input logic [15:0] m, input logic [1:0] ack);
    exp_q.push_back({k, a, d, m, ack});
  endtask
  // avalon master: hold until waitrequest low is sampled, then release
  task automatic av(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) fail("avalon no answer");
    if (!w) rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic prog(input logic ch, input logic [25:0] ra, input logic [25:0] ta,
      input logic [19:0] cnt, input logic [12:0] ctl);
    logic [6:0] b;
    b = ch ? dma_pkg::OFF_CH1 : 7'h00;
    av(1'b1, b | 7'(dma_pkg::REG_REQ_ADDR), 32'(ra));
    av(1'b1, b | 7'(dma_pkg::REG_TGT_ADDR), 32'(ta));
    av(1'b1, b | 7'(dma_pkg::REG_COUNT), 32'(cnt));
    av(1'b1, b | 7'(dma_pkg::REG_CTRL), 32'(ctl));
  endtask
  // status polled, bounded; rd keeps the last status read
  task automatic wait_st(input int bitn);
    int n;
    n = 0;
    do begin
      av(1'b0, dma_pkg::OFF_STATUS, 32'h0);
      n++;
    end while (rd[bitn] !== 1'b1 && n < 400);
    if (rd[bitn] !== 1'b1) fail("status bit never set");
  endtask
  always @(posedge mclk) begin
    if (!sys_rst && eop_oe === 1'b1) begin
      n_oe++;
      cmp32({31'h0, eop_out}, 32'h0);
    end
    if (!sys_rst && bus_ready === 1'b1 && (side_io_rd || side_io_wr)) n_side++;
    if (!sys_rst && bus_ready === 1'b1 && (mem_rd | mem_wr | io_rd | io_wr)) begin
      n_cyc++;
      if (!loose && exp_q.size() == 0) fail("unexpected bus cycle");
      else if (!loose) cmp_bus(exp_q.pop_front(), {bus_word, mem_rd, mem_wr, io_rd, io_wr,
          bus_addr, bus_wdata, 16'h0, ack_n});
    end
  end
  task automatic final_report();
    $display("mismatches %0d, samples checked %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    fail("watchdog");
    final_report();
  end
  initial begin
    logic [31:0] r, t;
    int eo, m, base;
    eo = 0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int a = 0; a < 11; a++) begin
      av(1'b0, 7'(a * 4), 32'h0);
      cmp32(rd, 32'h0);
    end
    t = xs();
    av(1'b1, 7'(dma_pkg::REG_COUNT), t);
    av(1'b1, 7'h28, t);
    av(1'b0, 7'(dma_pkg::REG_COUNT), 32'h0);
    cmp32(rd, {12'h0, t[19:0]});
    av(1'b0, 7'h28, 32'h0);
    cmp32(rd, 32'h0);
    // every hardware source of each channel, one byte fly-by each
    for (int ch = 0; ch < 2; ch++) begin
      for (int s = 0; s < 8; s++) begin
        t = xs();
        slow <= t[27:26];
        prog(ch[0], ~t[25:0], t[25:0], 20'h0, 13'h0103 | 13'(s << 10));
        ex(5'b00100, t[25:0], 16'h0, 16'h0, ch ? 2'b01 : 2'b10);
        hw[map[ch][s]] <= 1'b1;
        wait_st(2 + ch);
        hw <= 10'h0;
        eo++;
        cmp32(n_oe, eo);
        cmp32(exp_q.size(), 32'h0);
        av(1'b1, dma_pkg::OFF_STATUS, 32'h3f);
      end
    end
    cmp32(n_side, 32'h10);
    // word fly-by toward requester, target stepping down, software request
    t = xs() & 32'h03fffffe;
    prog(1'b1, 26'h3ffffff, t[25:0], 20'h3, 13'h014f);
    ex(5'b11000, t[25:0], 16'h0, 16'h0, 2'b01);
    ex(5'b11000, 26'(t - 2), 16'h0, 16'h0, 2'b01);
    av(1'b1, dma_pkg::OFF_SWREQ, 32'h2);
    wait_st(3);
    eo++;
    cmp32(n_oe, eo);
    av(1'b0, dma_pkg::OFF_CH1 | 7'(dma_pkg::REG_COUNT), 32'h0);
    cmp32(rd, 32'h000fffff);
    av(1'b0, dma_pkg::OFF_CH1 | 7'(dma_pkg::REG_TGT_ADDR), 32'h0);
    cmp32(rd, 32'(26'(t - 4)));
    cmp32(n_side, 32'h12);
    av(1'b1, dma_pkg::OFF_STATUS, 32'h3f);
    // fly-by refused with io target: two-cycle words, io both sides, requester held
    r = xs();
    t = xs();
    prog(1'b1, r[25:0], t[25:0], 20'h3, 13'h032f);
    ex(5'b10010, t[25:0], 16'h0, 16'h0, 2'b11);
    ex(5'b10010, 26'(t + 2), 16'h0, 16'h0, 2'b11);
    ex(5'b10001, r[25:0], {2{t[7:0] ^ 8'ha5}}, 16'hffff, 2'b01);
    ex(5'b10001, r[25:0], {2{8'(t + 2) ^ 8'ha5}}, 16'hffff, 2'b01);
    av(1'b1, dma_pkg::OFF_SWREQ, 32'h2);
    wait_st(3);
    eo++;
    cmp32(n_oe, eo);
    cmp32(exp_q.size(), 32'h0);
    av(1'b0, dma_pkg::OFF_CH1 | 7'(dma_pkg::REG_REQ_ADDR), 32'h0);
    cmp32(rd, 32'(r[25:0]));
    av(1'b1, dma_pkg::OFF_STATUS, 32'h3f);
    // two-cycle memory to memory: partial and full buffer fills
    for (int c = 2; c <= 5; c += 3) begin
      r = xs();
      t = xs();
      slow <= r[31:30];
      prog(1'b0, r[25:0], t[25:0], 20'(c), 13'h0001);
      for (int g = 0; g <= c; g += 4) begin
        for (int k = g; k <= c && k < g + 4; k++)
          ex(5'b01000, 26'(r + k), 16'h0, 16'h0, 2'b10);
        for (int k = g; k <= c && k < g + 4; k++)
          ex(5'b00100, 26'(t + k), 16'(8'(r + k) ^ 8'ha5), 16'h00ff, 2'b11);
      end
      av(1'b1, dma_pkg::OFF_SWREQ, 32'h1);
      wait_st(2);
      eo++;
      cmp32(n_oe, eo);
      cmp32(exp_q.size(), 32'h0);
      av(1'b1, dma_pkg::OFF_STATUS, 32'h3f);
    end
    // outside stop in mid-buffer: terminated, count shows units moved
    loose <= 1'b1;
    slow <= 2'h1;
    prog(1'b0, 26'h0, 26'h100, 20'h0ff, 13'h0103);
    hw[0] <= 1'b1;
    base = n_cyc;
    m = 0;
    while (n_cyc - base < 3 && m < 500) begin
      @(posedge mclk);
      m++;
    end
    stop_n <= 1'b0;
    repeat (4) @(posedge mclk);
    hw <= 10'h0;
    repeat (4) @(posedge mclk);
    stop_n <= 1'b1;
    wait_st(4);
    cmp32(rd & 32'h3c, 32'h10);
    cmp32(n_oe, eo);
    av(1'b0, 7'(dma_pkg::REG_COUNT), 32'h0);
    cmp32(rd, 32'(20'h0ff - 20'(n_cyc - base)));
    loose <= 1'b0;
    final_report();
  end
endmodule
